// *** tsi_pkg.sv ***
package tsi_pkg;

	// Configuration register and its reset value.
	localparam logic [1:0] TSI_SENSOR_SETUP_OFFSET = 2'h1;
	localparam logic [6:0] TSI_SENSOR_SETUP_RST = 7'h00;

	// Field positions inside the configuration register.
	localparam int TSI_RESOLUTION_SEL_HI_POS = 6;
	localparam int TSI_RESOLUTION_SEL_LO_POS = 5;
	localparam int TSI_FAULT_COUNT_HI_POS = 4;
	localparam int TSI_FAULT_COUNT_LO_POS = 3;
	localparam int TSI_ALARM_ACTIVE_LEVEL_POS = 2;
	localparam int TSI_THERMOSTAT_BEHAVIOUR_SEL_POS = 1;
	localparam int TSI_SLEEP_REQUEST_POS = 0;

	// Register select codes.
	localparam logic [1:0] TSI_SEL_TEMP = 2'h0;
	localparam logic [1:0] TSI_SEL_SETUP = TSI_SENSOR_SETUP_OFFSET;
	localparam logic [1:0] TSI_SEL_HYST = 2'h2;
	localparam logic [1:0] TSI_SEL_OVER = 2'h3;
	localparam logic [1:0] TSI_SEL_RST = TSI_SEL_TEMP;

	// Bus address and commands.
	localparam logic [3:0] TSI_ADDR_UPPER = 4'h9;
	localparam logic [7:0] TSI_SOFT_POR_CMD = 8'h54;
	localparam logic [3:0] TSI_BITS_PER_BYTE = 4'h8;

	// Resolution in bits per select code.
	localparam logic [3:0] TSI_RES_BITS_0 = 4'h9;
	localparam logic [3:0] TSI_RES_BITS_1 = 4'hA;
	localparam logic [3:0] TSI_RES_BITS_2 = 4'hB;
	localparam logic [3:0] TSI_RES_BITS_3 = 4'hC;

	// Longest conversion time in milliseconds per select code.
	localparam int TSI_CONV_MS_0 = 25;
	localparam int TSI_CONV_MS_1 = 50;
	localparam int TSI_CONV_MS_2 = 100;
	localparam int TSI_CONV_MS_3 = 200;

	// Consecutive out-of-limit conversions per fault code.
	localparam logic [2:0] TSI_FAULT_N_0 = 3'h1;
	localparam logic [2:0] TSI_FAULT_N_1 = 3'h2;
	localparam logic [2:0] TSI_FAULT_N_2 = 3'h4;
	localparam logic [2:0] TSI_FAULT_N_3 = 3'h6;

	typedef enum logic [2:0] {
		TSI_ST_IDLE,
		TSI_ST_ADDR,
		TSI_ST_PTR,
		TSI_ST_WR,
		TSI_ST_RD
	} tsi_state_t;

endpackage : tsi_pkg

// *** tsi_link_capture.sv ***
`timescale 1ns/10ps

module tsi_link_capture
(
	// Link clock and reset.
	input wire logic scl_i,
	input wire logic rst_n_i,
	// Serial data.
	input wire logic sda_i,
	// Captured bits and bit event.
	output logic [7:0] byte_o,
	output logic toggle_o
);

	logic [7:0] byte_nxt;
	logic toggle_nxt;

	// Shifts in one bit per rising clock edge, first bit ending up highest.
	always_comb
	begin
		byte_nxt = {byte_o[6:0], sda_i};
		toggle_nxt = ~toggle_o;
	end

	always_ff @(posedge scl_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			byte_o <= 8'h00;
			toggle_o <= 1'b0;
		end
		else
		begin
			byte_o <= byte_nxt;
			toggle_o <= toggle_nxt;
		end
	end

endmodule : tsi_link_capture

// *** tsi_slave.sv ***
`timescale 1ns/10ps

// Functional notes
// - Top setup bit ignores writes, reads zero.
// - Setup register clears to zero at power-up.
// - Setup fields: resolution, fault, level, mode, sleep.
// - Resolution codes give nine to twelve bits.
// - Fault codes give one, two, four, six.
// - Level bit picks alarm active polarity.
// - Mode bit picks comparator or interrupt.
// - Sleep bit set requests shutdown mode.
// - Select codes: temp, setup, hysteresis, over-limit.
// - Register select persists across transactions.
// - Register select starts at temperature.
// - Slave only; data line open-drain.
// - Bytes shift most significant bit first.
// - Receiver pulls data low for acknowledge.
// - Address is 1001 plus three straps.
// - Address byte ends with direction bit.
// - Byte 54h after write address resets.
module tsi_slave
	import tsi_pkg::*;
(
	// System clock and reset.
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// Two-wire link.
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	// Address straps.
	input wire logic [2:0] ADDR_STRAP_I,
	// Words from the measurement side.
	input wire logic [15:0] TEMP_WORD_I,
	input wire logic [15:0] HYST_LIMIT_I,
	input wire logic [15:0] OVER_LIMIT_I,
	// Setup fields and register select.
	output logic [1:0] RESOLUTION_SEL_O,
	output logic [3:0] RESOLUTION_BITS_O,
	output logic [1:0] FAULT_COUNT_SEL_O,
	output logic [2:0] FAULT_LIMIT_O,
	output logic ALARM_ACTIVE_LEVEL_O,
	output logic THERMOSTAT_BEHAVIOUR_SEL_O,
	output logic SLEEP_REQUEST_O,
	output logic [1:0] REG_SELECT_O,
	// Limit writes.
	output logic LIMIT_WE_O,
	output logic [1:0] LIMIT_SEL_O,
	output logic [15:0] LIMIT_DATA_O
);

	logic [7:0] cap_byte;
	logic [1:0] scl_sync_r, sda_sync_r, tog_sync_r;
	logic [5:0] strap_sync_r;
	logic cap_toggle, scl_d_r, sda_d_r, tog_d_r;
	logic start_det, stop_det, scl_fall, bit_ev, soft_por;

	tsi_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic ack_r, ack_nxt, ackd_r, ackd_nxt, dir_r, dir_nxt;
	logic idx_r, idx_nxt, oe_r, oe_nxt, lim_we_r, lim_we_nxt;
	logic [1:0] sel_r, sel_nxt, lim_sel_r, lim_sel_nxt;
	logic [6:0] setup_r, setup_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic [15:0] lim_data_r, lim_data_nxt;
	logic [3:0] res_bits_r, res_bits_nxt;
	logic [2:0] fault_lim_r, fault_lim_nxt;

	// Bits sampled on the link clock itself.
	tsi_link_capture u_capture
	(
		.scl_i(SCL_I),
		.rst_n_i(RESETN_I),
		.sda_i(SDA_I),
		.byte_o(cap_byte),
		.toggle_o(cap_toggle)
	);

	assign start_det = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
	assign stop_det = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
	assign scl_fall = scl_d_r & ~scl_sync_r[1];
	assign bit_ev = tog_sync_r[1] ^ tog_d_r;

	// Selects the byte to send from the addressed register.
	function automatic logic [7:0] tsi_pick(input logic [1:0] sel, input logic idx, input logic [6:0] setup,
		input logic [15:0] temp, input logic [15:0] hyst, input logic [15:0] over);
		logic [15:0] word;
		word = 16'h0000;
		unique case (sel)
			TSI_SEL_TEMP: word = temp;
			TSI_SEL_SETUP: word = {1'b0, setup, 1'b0, setup};
			TSI_SEL_HYST: word = hyst;
			TSI_SEL_OVER: word = over;
		endcase
		return idx ? word[7:0] : word[15:8];
	endfunction : tsi_pick

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		ack_nxt = ack_r;
		ackd_nxt = ackd_r;
		dir_nxt = dir_r;
		idx_nxt = idx_r;
		sel_nxt = sel_r;
		setup_nxt = setup_r;
		tx_nxt = tx_r;
		oe_nxt = oe_r;
		lim_we_nxt = 1'b0;
		lim_sel_nxt = lim_sel_r;
		lim_data_nxt = lim_data_r;
		soft_por = 1'b0;
		if (start_det)
		begin
			// A start or repeated start restarts byte framing.
			state_nxt = TSI_ST_ADDR;
			cnt_nxt = 4'h0;
			ack_nxt = 1'b0;
			ackd_nxt = 1'b0;
			idx_nxt = 1'b0;
			oe_nxt = 1'b0;
		end
		else if (stop_det)
		begin
			state_nxt = TSI_ST_IDLE;
			ack_nxt = 1'b0;
			ackd_nxt = 1'b0;
			oe_nxt = 1'b0;
		end
		else
		begin
			if (bit_ev && state_r != TSI_ST_IDLE)
			begin
				if (!ack_r)
				begin
					cnt_nxt = cnt_r + 4'h1;
					if (cnt_r == TSI_BITS_PER_BYTE - 4'h1)
					begin
						ack_nxt = 1'b1;
						ackd_nxt = 1'b1;
						unique case (state_r)
							TSI_ST_ADDR:
							begin
								if (cap_byte[7:1] != {TSI_ADDR_UPPER, strap_sync_r[5:3]})
								begin
									state_nxt = TSI_ST_IDLE;
									ack_nxt = 1'b0;
									ackd_nxt = 1'b0;
								end
								else
									dir_nxt = cap_byte[0];
							end
							TSI_ST_PTR:
							begin
								if (cap_byte == TSI_SOFT_POR_CMD)
									soft_por = 1'b1;
								else
									sel_nxt = cap_byte[1:0];
							end
							TSI_ST_WR:
							begin
								if (sel_r == TSI_SEL_SETUP)
									setup_nxt = cap_byte[6:0];
								else if (sel_r != TSI_SEL_TEMP)
								begin
									lim_sel_nxt = sel_r;
									if (!idx_r)
										lim_data_nxt[15:8] = cap_byte;
									else
									begin
										lim_data_nxt[7:0] = cap_byte;
										lim_we_nxt = 1'b1;
									end
								end
							end
							TSI_ST_RD: ackd_nxt = 1'b0;
							default:
							begin
								ack_nxt = 1'b0;
								ackd_nxt = 1'b0;
							end
						endcase
					end
				end
				else
				begin
					// Ninth clock: the acknowledge bit has been sampled.
					ack_nxt = 1'b0;
					ackd_nxt = 1'b0;
					cnt_nxt = 4'h0;
					unique case (state_r)
						TSI_ST_ADDR:
						begin
							idx_nxt = 1'b0;
							if (dir_r)
							begin
								state_nxt = TSI_ST_RD;
								tx_nxt = tsi_pick(sel_r, 1'b0, setup_r, TEMP_WORD_I, HYST_LIMIT_I, OVER_LIMIT_I);
							end
							else
								state_nxt = TSI_ST_PTR;
						end
						TSI_ST_PTR:
						begin
							state_nxt = TSI_ST_WR;
							idx_nxt = 1'b0;
						end
						TSI_ST_WR: idx_nxt = ~idx_r;
						TSI_ST_RD:
						begin
							if (cap_byte[0])
								state_nxt = TSI_ST_IDLE;
							else
							begin
								idx_nxt = ~idx_r;
								tx_nxt = tsi_pick(sel_r, ~idx_r, setup_r, TEMP_WORD_I, HYST_LIMIT_I, OVER_LIMIT_I);
							end
						end
						default: state_nxt = TSI_ST_IDLE;
					endcase
				end
			end
			if (scl_fall)
			begin
				// The data line only changes while the clock is low.
				if (ack_r && ackd_r)
					oe_nxt = 1'b1;
				else if (state_r == TSI_ST_RD && !ack_r)
				begin
					oe_nxt = ~tx_r[7];
					tx_nxt = {tx_r[6:0], 1'b0};
				end
				else
					oe_nxt = 1'b0;
			end
		end
		if (soft_por)
		begin
			state_nxt = TSI_ST_IDLE;
			ack_nxt = 1'b0;
			ackd_nxt = 1'b0;
			oe_nxt = 1'b0;
			setup_nxt = TSI_SENSOR_SETUP_RST;
			sel_nxt = TSI_SEL_RST;
		end
		unique case (setup_nxt[TSI_RESOLUTION_SEL_HI_POS:TSI_RESOLUTION_SEL_LO_POS])
			2'h0: res_bits_nxt = TSI_RES_BITS_0;
			2'h1: res_bits_nxt = TSI_RES_BITS_1;
			2'h2: res_bits_nxt = TSI_RES_BITS_2;
			2'h3: res_bits_nxt = TSI_RES_BITS_3;
		endcase
		unique case (setup_nxt[TSI_FAULT_COUNT_HI_POS:TSI_FAULT_COUNT_LO_POS])
			2'h0: fault_lim_nxt = TSI_FAULT_N_0;
			2'h1: fault_lim_nxt = TSI_FAULT_N_1;
			2'h2: fault_lim_nxt = TSI_FAULT_N_2;
			2'h3: fault_lim_nxt = TSI_FAULT_N_3;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			state_r <= TSI_ST_IDLE;
			cnt_r <= 4'h0;
			ack_r <= 1'b0;
			ackd_r <= 1'b0;
			dir_r <= 1'b0;
			idx_r <= 1'b0;
			sel_r <= TSI_SEL_RST;
			setup_r <= TSI_SENSOR_SETUP_RST;
			tx_r <= 8'h00;
			oe_r <= 1'b0;
			lim_we_r <= 1'b0;
			lim_sel_r <= TSI_SEL_HYST;
			lim_data_r <= 16'h0000;
			res_bits_r <= TSI_RES_BITS_0;
			fault_lim_r <= TSI_FAULT_N_0;
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			tog_sync_r <= 2'h0;
			strap_sync_r <= 6'h00;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			tog_d_r <= 1'b0;
			SDA_O <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			ack_r <= ack_nxt;
			ackd_r <= ackd_nxt;
			dir_r <= dir_nxt;
			idx_r <= idx_nxt;
			sel_r <= sel_nxt;
			setup_r <= setup_nxt;
			tx_r <= tx_nxt;
			oe_r <= oe_nxt;
			lim_we_r <= lim_we_nxt;
			lim_sel_r <= lim_sel_nxt;
			lim_data_r <= lim_data_nxt;
			res_bits_r <= res_bits_nxt;
			fault_lim_r <= fault_lim_nxt;
			scl_sync_r <= {scl_sync_r[0], SCL_I};
			sda_sync_r <= {sda_sync_r[0], SDA_I};
			tog_sync_r <= {tog_sync_r[0], cap_toggle};
			strap_sync_r <= {strap_sync_r[2:0], ADDR_STRAP_I};
			scl_d_r <= scl_sync_r[1];
			sda_d_r <= sda_sync_r[1];
			tog_d_r <= tog_sync_r[1];
			SDA_O <= 1'b0;
		end
	end

	assign SDA_OE_O = oe_r;
	assign RESOLUTION_SEL_O = setup_r[TSI_RESOLUTION_SEL_HI_POS:TSI_RESOLUTION_SEL_LO_POS];
	assign RESOLUTION_BITS_O = res_bits_r;
	assign FAULT_COUNT_SEL_O = setup_r[TSI_FAULT_COUNT_HI_POS:TSI_FAULT_COUNT_LO_POS];
	assign FAULT_LIMIT_O = fault_lim_r;
	assign ALARM_ACTIVE_LEVEL_O = setup_r[TSI_ALARM_ACTIVE_LEVEL_POS];
	assign THERMOSTAT_BEHAVIOUR_SEL_O = setup_r[TSI_THERMOSTAT_BEHAVIOUR_SEL_POS];
	assign SLEEP_REQUEST_O = setup_r[TSI_SLEEP_REQUEST_POS];
	assign REG_SELECT_O = sel_r;
	assign LIMIT_WE_O = lim_we_r;
	assign LIMIT_SEL_O = lim_sel_r;
	assign LIMIT_DATA_O = lim_data_r;

endmodule : tsi_slave

// *** tsi_slave_properties.sv ***
`timescale 1ns/10ps

module tsi_slave_properties
(
	// Watched ports.
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic SCL_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_O,
	input wire logic [1:0] RESOLUTION_SEL_O,
	input wire logic [3:0] RESOLUTION_BITS_O,
	input wire logic [1:0] FAULT_COUNT_SEL_O,
	input wire logic [2:0] FAULT_LIMIT_O,
	input wire logic ALARM_ACTIVE_LEVEL_O,
	input wire logic THERMOSTAT_BEHAVIOUR_SEL_O,
	input wire logic SLEEP_REQUEST_O,
	input wire logic [1:0] REG_SELECT_O,
	input wire logic LIMIT_WE_O,
	input wire logic [1:0] LIMIT_SEL_O
);
	logic [6:0] setup;
	assign setup = {RESOLUTION_SEL_O, FAULT_COUNT_SEL_O, ALARM_ACTIVE_LEVEL_O, THERMOSTAT_BEHAVIOUR_SEL_O, SLEEP_REQUEST_O};
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);
	a_sda_never_high: assert property (!SDA_O)
		else $error("data line driven high");
	a_res_bits_map: assert property (
		$stable(RESOLUTION_SEL_O) && $stable(RESOLUTION_BITS_O) |-> RESOLUTION_BITS_O == 4'h9 + 4'(RESOLUTION_SEL_O))
		else $error("resolution decode wrong");
	a_fault_map: assert property (
		$stable(FAULT_COUNT_SEL_O) && $stable(FAULT_LIMIT_O)
		|-> FAULT_LIMIT_O == ((FAULT_COUNT_SEL_O == 2'h3) ? 3'h6 : 3'h1 << FAULT_COUNT_SEL_O))
		else $error("fault decode wrong");
	a_reset_defaults: assert property ($rose(RESETN_I) |-> setup == 7'h00 && REG_SELECT_O == 2'h0 && !SDA_OE_O)
		else $error("reset defaults wrong");
	a_limit_pulse_once: assert property (LIMIT_WE_O |=> !LIMIT_WE_O)
		else $error("limit strobe too long");
	a_limit_target: assert property (LIMIT_WE_O |-> LIMIT_SEL_O[1] && LIMIT_SEL_O == REG_SELECT_O)
		else $error("limit strobe target wrong");
	a_ack_on_low: assert property ($rose(SDA_OE_O) |-> !SCL_I)
		else $error("data pulled while clock high");
	a_setup_on_high: assert property (!$stable(setup) || !$stable(REG_SELECT_O) |-> SCL_I)
		else $error("setup changed off a sampling phase");
endmodule : tsi_slave_properties

bind tsi_slave tsi_slave_properties u_props (.*);

// *** tsi_i2c_master.sv ***
`timescale 1ns/10ps

module tsi_i2c_master
(
	// Bus lines.
	output logic scl_o,
	output logic sda_oe_o,
	input wire logic sda_i
);
	localparam realtime Q = 31.25;
	initial
	begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// The clock stands high between frames.
	task start();
		#Q sda_oe_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b1;
		#Q scl_o = 1'b0;
	endtask : start
	task stop();
		#Q sda_oe_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b0;
		#Q;
	endtask : stop
	task clk_bit(input logic b, output logic r);
		#Q sda_oe_o = !b;
		#Q scl_o = 1'b1;
		#Q r = sda_i;
		#Q scl_o = 1'b0;
	endtask : clk_bit
	task xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], q[i]);
		clk_bit(a, k);
	endtask : xfer
endmodule : tsi_i2c_master

// *** testbench.sv ***
`timescale 1ns/10ps

module testbench
	import tsi_pkg::*;
;
	localparam logic [15:0] WD [3] = '{16'hA5C3, 16'h1E87, 16'h5A3C};
	localparam logic [1:0] SEL [3] = '{2'h0, 2'h2, 2'h3};
	localparam logic [7:0] BAD [3] = '{8'h98, 8'hDA, 8'h1B};
	localparam logic [2:0] LIMS [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
	localparam logic [7:0] AW = {TSI_ADDR_UPPER, 3'h5, 1'b0};
	localparam logic [7:0] AR = {TSI_ADDR_UPPER, 3'h5, 1'b1};
	logic clk = 1'b0;
	logic rst_n = 1'b1;
	logic [2:0] strap = 3'h0;
	logic [15:0] temp = 16'h0000;
	logic [15:0] hyst = 16'h0000;
	logic [15:0] over = 16'h0000;
	logic scl, m_oe, sda, sda_o, sda_oe, lvl, tmode, sleep, we;
	logic [1:0] rsel, fsel, psel, lsel;
	logic [3:0] rbits;
	logic [2:0] flim;
	logic [15:0] ldata, fields;
	logic [17:0] cap = 18'h0_0000;
	logic [7:0] we_n = 8'h00;
	logic [7:0] d;
	int failures = 0;
	int n_checks = 0;
	assign sda = !(m_oe | sda_oe);
	assign fields = {psel, rsel, rbits, fsel, flim, lvl, tmode, sleep};

	tsi_slave DUT (.CLK_I(clk), .RESETN_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
		.ADDR_STRAP_I(strap), .TEMP_WORD_I(temp), .HYST_LIMIT_I(hyst), .OVER_LIMIT_I(over),
		.RESOLUTION_SEL_O(rsel), .RESOLUTION_BITS_O(rbits), .FAULT_COUNT_SEL_O(fsel), .FAULT_LIMIT_O(flim),
		.ALARM_ACTIVE_LEVEL_O(lvl), .THERMOSTAT_BEHAVIOUR_SEL_O(tmode), .SLEEP_REQUEST_O(sleep),
		.REG_SELECT_O(psel), .LIMIT_WE_O(we), .LIMIT_SEL_O(lsel), .LIMIT_DATA_O(ldata));
	tsi_i2c_master master (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));

	initial
	begin
		forever #2.5 clk = !clk;
	end
	always @(posedge clk)
	begin
		if (we === 1'b1)
		begin
			we_n <= we_n + 8'h01;
			cap <= {lsel, ldata};
		end
	end

	task test_done();
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task wb(input logic [7:0] b, input logic e);
		logic [7:0] q;
		logic k;
		master.xfer(b, 1'b1, q, k);
		chk(32'(k), 32'(e));
	endtask : wb
	task rb(input logic a, input logic [7:0] e);
		logic [7:0] q;
		logic k;
		master.xfer(8'hFF, a, q, k);
		chk(32'(q), 32'(e));
	endtask : rb
	function automatic logic [15:0] exp_f(input logic [6:0] s, input logic [1:0] p);
		return {p, s[6:5], 4'h9 + 4'(s[6:5]), s[4:3], LIMS[s[4:3]], s[2:0]};
	endfunction : exp_f

	initial
	begin
		#400_000;
		failures++;
		test_done();
	end
	initial
	begin
		rst_n <= 1'b0;
		@(posedge clk);
		strap <= 3'h5;
		temp <= WD[0];
		hyst <= WD[1];
		over <= WD[2];
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk(32'(fields), 32'(exp_f(7'h00, 2'h0)));
		master.start();
		wb(AR, 1'b0);
		rb(1'b0, WD[0][15:8]);
		rb(1'b1, WD[0][7:0]);
		master.stop();
		for (int i = 0; i < 3; i++)
		begin
			master.start();
			wb(BAD[i], 1'b1);
			master.stop();
		end
		for (int k = 0; k < 4; k++)
		begin
			d = {1'b1, 2'(k), 2'(k), k[0], k[1], k[0]};
			master.start();
			wb(AW, 1'b0);
			wb(8'h01 | 8'(k << 2), 1'b0);
			wb(d, 1'b0);
			master.stop();
			chk(32'(fields), 32'(exp_f(d[6:0], 2'h1)));
			master.start();
			wb(AR, 1'b0);
			rb(1'b1, {1'b0, d[6:0]});
			master.stop();
		end
		master.start();
		wb(AW, 1'b0);
		wb(8'h02, 1'b0);
		wb(8'h12, 1'b0);
		wb(8'h34, 1'b0);
		master.stop();
		chk({6'h00, we_n, cap}, {6'h00, 8'h01, 2'h2, 16'h1234});
		for (int i = 0; i < 3; i++)
		begin
			master.start();
			wb(AW, 1'b0);
			wb({6'h00, SEL[i]}, 1'b0);
			master.start();
			wb(AR, 1'b0);
			rb(1'b0, WD[i][15:8]);
			rb(1'b1, WD[i][7:0]);
			master.stop();
		end
		master.start();
		wb(AW, 1'b0);
		wb(TSI_SOFT_POR_CMD, 1'b1);
		master.stop();
		chk(32'(fields), 32'(exp_f(7'h00, 2'h0)));
		test_done();
	end
endmodule : testbench
